// >>> acss_pkg.sv
// Constants, types and helpers shared by the converter cycle sequencer
package acss_pkg;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int SYS_CLK_MHZ = 20;        // System clock rate, MHz
    localparam int POR_TIME_US = 1000;      // Power-on reset pulse, microseconds
    localparam int POR_CYCLES_DEF = POR_TIME_US * SYS_CLK_MHZ;
    localparam int CONV_CYCLES_DEF = 64;    // Conversion length, clocks
    localparam int CAL_CYCLES_DEF = 8;      // Calibration slot inside a conversion
    localparam int SCK_DIV_DEF = 4;         // Internal serial clock half period

    // ========================================================================
    // Link word layout
    // ========================================================================
    localparam int WORD_BITS = 32;          // Bits in one output word
    localparam int CMD_BITS = 8;            // Bits in one channel-select word
    localparam int ADDR_BITS = 5;           // Channel address width
    localparam int DATA_BITS = 24;          // Converter result width
    localparam logic [5:0] CNT_WORD_END = 6'h20;  // Count after the last bit
    localparam logic [5:0] CNT_CMD_LAST = 6'h07;  // Count at the last command bit
    localparam int CMD_CTL_POS = 5;         // Control field sits at [7:5]
    localparam logic [2:0] CTL_LOAD = 3'h5;  // Load a new address
    localparam logic [2:0] CTL_KEEP = 3'h4;  // Keep the address
    localparam logic [2:0] CTL_KEEP0 = 3'h0; // Keep the address, line tied low
    localparam logic [4:0] ADDR_RESET = 5'h00;     // First pair after power-up
    localparam logic [31:0] CODE_OVER = 32'h30000000;  // Input above range
    localparam logic [31:0] CODE_UNDER = 32'h0fffffff; // Input below range

    // ========================================================================
    // Cycle states
    // ========================================================================
    typedef enum logic [2:0] {
        ST_CONV = 3'b001,
        ST_SLEEP = 3'b010,
        ST_OUT = 3'b100
    } acss_state_t;

    // Build the output word; out-of-range codes cannot collide with data,
    // since in-range words always have bits 29 and 28 unequal
    function automatic logic [31:0] acss_mk_word(input logic [23:0] data,
                                                input logic over, input logic under);
        if (over) begin
            acss_mk_word = CODE_OVER;
        end else if (under) begin
            acss_mk_word = CODE_UNDER;
        end else begin
            acss_mk_word = {2'h0, ~data[23], data, 5'h00};
        end
    endfunction : acss_mk_word

endpackage : acss_pkg

// >>> acss_sequencer.sv
// Conversion / sleep / serial output cycle sequencer of a multichannel converter
`timescale 1ns/1ps

module acss_sequencer import acss_pkg::*; #(
    parameter int POR_CYCLES = POR_CYCLES_DEF,
    parameter int CONV_CYCLES = CONV_CYCLES_DEF,
    parameter int CAL_CYCLES = CAL_CYCLES_DEF,
    parameter int SCK_DIV = SCK_DIV_DEF
) (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Supply monitor
    input wire logic supply_low,
    // Serial link pins
    input wire logic link_sck,
    input wire logic sck_lvl,
    output logic sck_o,
    output logic sck_oe,
    input wire logic cs_n,
    input wire logic serial_in_line,
    output logic serial_out_line,
    output logic serial_out_oe,
    // Converter core side
    input wire logic [23:0] conv_data,
    input wire logic conv_over,
    input wire logic conv_under,
    output logic conv_start,
    output logic cal_phase,
    output logic [4:0] chan_addr,
    output logic sck_int_mode
);

    // ========================================================================
    // Reset and power-on pulse
    // ========================================================================
    localparam int PW = $clog2(POR_CYCLES + 1);
    localparam logic [PW-1:0] POR_LOAD = PW'(POR_CYCLES);
    logic [1:0] rsync_q;          // External reset synchroniser
    logic [1:0] low_sync_q;       // Supply-low synchroniser
    logic [PW-1:0] por_cnt_q, por_cnt_d;
    logic rst_int_n_q, rst_int_n_d;   // Internal reset, clears every register but the power-on ones and rsync_q
    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    // Pulse restarts each time the supply dips
    always_comb begin
        por_cnt_d = por_cnt_q;
        if (low_sync_q[1]) begin
            por_cnt_d = POR_LOAD;
        end else if (por_cnt_q != '0) begin
            por_cnt_d = por_cnt_q - PW'(1);
        end
        rst_int_n_d = (por_cnt_q == '0) && !low_sync_q[1];
    end
    // Power-on registers
    always_ff @(posedge sys_clk or negedge rsync_q[1]) begin
        if (!rsync_q[1]) begin
            low_sync_q <= 2'h3;
            por_cnt_q <= POR_LOAD;
            rst_int_n_q <= 1'b0;
        end else begin
            low_sync_q <= {low_sync_q[0], supply_low};
            por_cnt_q <= por_cnt_d;
            rst_int_n_q <= rst_int_n_d;
        end
    end

    // ========================================================================
    // Pin and link synchronisers
    // ========================================================================
    logic [1:0] cs_sync_q;        // Select level
    logic [1:0] sck_sync_q;       // Clock pin level for mode pick
    logic [1:0] start_sync_q;     // First rising edge seen on link
    logic [1:0] done_sync_q;      // All bits clocked out
    logic cs_prev_q;              // Last synchronised select, for edge
    logic started_q;              // Link side, first edge taken
    logic done_q;                 // Link side, word complete
    always_ff @(posedge sys_clk or negedge rst_int_n_q) begin
        if (!rst_int_n_q) begin
            cs_sync_q <= 2'h3;
            sck_sync_q <= 2'h0;
            start_sync_q <= 2'h0;
            done_sync_q <= 2'h0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], cs_n};
            sck_sync_q <= {sck_sync_q[0], sck_lvl};
            start_sync_q <= {start_sync_q[0], started_q};
            done_sync_q <= {done_sync_q[0], done_q};
        end
    end

    // ========================================================================
    // Cycle state machine
    // ========================================================================
    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
    localparam logic [CW-1:0] CAL_END = CW'(CAL_CYCLES);
    localparam int DW = $clog2(SCK_DIV + 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(SCK_DIV - 1);
    acss_state_t state_q, state_d;
    logic [CW-1:0] conv_cnt_q, conv_cnt_d;   // Position inside the conversion
    logic [31:0] result_q, result_d;         // Held output word
    logic seen_start_q, seen_start_d;        // Transfer has begun
    logic busy_q, busy_d;                    // Conversion in progress
    logic oe_q, oe_d;                        // Output driven
    logic start_q, start_d;                  // Conversion start pulse
    logic cal_q, cal_d;                      // Calibration slot
    logic [4:0] addr_out_q, addr_out_d;      // Address used by this conversion
    logic mode_q, mode_d;                    // Internal serial clock chosen
    logic [DW-1:0] div_q, div_d;             // Internal clock divider
    logic sck_q, sck_d;
    logic sck_en_q, sck_en_d;
    logic [4:0] link_addr_q;                 // Address held on link side
    wire cs_hi = cs_sync_q[1];
    always_comb begin
        state_d = state_q;
        conv_cnt_d = conv_cnt_q;
        result_d = result_q;
        seen_start_d = seen_start_q;
        mode_d = mode_q;
        case (state_q)
            ST_CONV: begin
                seen_start_d = 1'b0;
                conv_cnt_d = conv_cnt_q + CW'(1);
                if (conv_cnt_q == CONV_LAST) begin
                    // One word per conversion, loaded once
                    result_d = acss_mk_word(conv_data, conv_over, conv_under);
                    conv_cnt_d = '0;
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!cs_hi) begin
                    state_d = ST_OUT;
                end
            end
            ST_OUT: begin
                if (start_sync_q[1]) begin
                    seen_start_d = 1'b1;
                end
                if (cs_hi) begin
                    // Abort after the first edge, else back to sleep
                    state_d = (seen_start_q || start_sync_q[1]) ? ST_CONV : ST_SLEEP;
                end else if (done_sync_q[1]) begin
                    state_d = ST_CONV;
                end
            end
            default: begin
                state_d = ST_CONV;
            end
        endcase
        // Clock source taken from pin level at select fall
        if (cs_prev_q && !cs_hi) begin
            mode_d = sck_sync_q[1];
        end
        busy_d = (state_d == ST_CONV);
        start_d = (state_d == ST_CONV) && (state_q != ST_CONV);
        cal_d = (state_d == ST_CONV) && (conv_cnt_d < CAL_END);
        addr_out_d = start_d ? link_addr_q : addr_out_q;
        oe_d = !cs_hi;
        // Internal clock only while output runs and bits remain
        sck_en_d = mode_q && (state_q == ST_OUT) && !done_sync_q[1] && !cs_hi;
        div_d = (div_q == DIV_LAST || !sck_en_q) ? '0 : div_q + DW'(1);
        sck_d = !sck_en_q ? 1'b0 : ((div_q == DIV_LAST) ? !sck_q : sck_q);
    end
    // Cycle registers; reset lands in conversion with status busy
    always_ff @(posedge sys_clk or negedge rst_int_n_q) begin
        if (!rst_int_n_q) begin
            state_q <= ST_CONV;
            conv_cnt_q <= '0;
            result_q <= 32'h0;
            seen_start_q <= 1'b0;
            busy_q <= 1'b1;
            oe_q <= 1'b0;
            start_q <= 1'b1;
            cal_q <= 1'b1;
            addr_out_q <= ADDR_RESET;
            mode_q <= 1'b0;
            cs_prev_q <= 1'b1;
            div_q <= '0;
            sck_q <= 1'b0;
            sck_en_q <= 1'b0;
        end else begin
            state_q <= state_d;
            conv_cnt_q <= conv_cnt_d;
            result_q <= result_d;
            seen_start_q <= seen_start_d;
            busy_q <= busy_d;
            oe_q <= oe_d;
            start_q <= start_d;
            cal_q <= cal_d;
            addr_out_q <= addr_out_d;
            mode_q <= mode_d;
            cs_prev_q <= cs_hi;
            div_q <= div_d;
            sck_q <= sck_d;
            sck_en_q <= sck_en_d;
        end
    end

    // ========================================================================
    // Link-clock logic
    // ========================================================================
    // Select high or a conversion clears the link side but the address, no edge needed; result_q static
    wire link_rst = cs_n || busy_q || !rst_int_n_q;
    logic [5:0] bit_cnt_q, bit_cnt_d;    // Rising edges taken
    logic [7:0] shin_q, shin_d;          // Command bits
    logic [7:0] cmd_word;
    logic [4:0] link_addr_d;
    logic dout_q, dout_d;
    logic started_d, done_d;
    always_comb begin
        cmd_word = {shin_q[6:0], serial_in_line};
        bit_cnt_d = (bit_cnt_q == CNT_WORD_END) ? bit_cnt_q : bit_cnt_q + 6'h01;
        shin_d = (bit_cnt_q <= CNT_CMD_LAST) ? cmd_word : shin_q;
        started_d = 1'b1;
        done_d = (bit_cnt_d == CNT_WORD_END);
        link_addr_d = link_addr_q;
        if (bit_cnt_q == CNT_CMD_LAST && cmd_word[7:CMD_CTL_POS] == CTL_LOAD) begin
            link_addr_d = cmd_word[ADDR_BITS-1:0];
        end
        // Next bit after bit_cnt_q edges; zero once the word is out
        dout_d = (bit_cnt_q < CNT_WORD_END) ? result_q[5'h1f - bit_cnt_q[4:0]] : 1'b0;
    end
    // Rising edge: count, sample the input line
    always_ff @(posedge link_sck or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_q <= 6'h00;
            shin_q <= 8'h00;
            started_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shin_q <= shin_d;
            started_q <= started_d;
            done_q <= done_d;
        end
    end
    // Address survives frames, as a cleared bit count holds it; internal reset clears it
    always_ff @(posedge link_sck or negedge rst_int_n_q) begin
        if (!rst_int_n_q) begin
            link_addr_q <= ADDR_RESET;
        end else begin
            link_addr_q <= link_addr_d;
        end
    end
    // Falling edge: present the next bit; first bit (zero) stands at reset
    always_ff @(negedge link_sck or posedge link_rst) begin
        if (link_rst) begin
            dout_q <= 1'b0;
        end else begin
            dout_q <= dout_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // Status high while converting, else the shift bit; gate kept as the bit outpaces sys_clk
    assign serial_out_line = busy_q | dout_q;
    assign serial_out_oe = oe_q;
    assign sck_o = sck_q;
    assign sck_oe = sck_en_q;
    assign conv_start = start_q;
    assign cal_phase = cal_q;
    assign chan_addr = addr_out_q;
    assign sck_int_mode = mode_q;

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_int_n_q);
    a_state_onehot: assert property ($onehot(state_q))
        else $error("cycle state not one-hot");
    a_conv_to_sleep: assert property (state_q == ST_CONV && conv_cnt_q == CONV_LAST |=>
        state_q == ST_SLEEP && result_q == $past(acss_mk_word(conv_data, conv_over, conv_under)))
        else $error("conversion end did not load and sleep");
    a_sleep_holds: assert property (state_q == ST_SLEEP && cs_hi |=> state_q == ST_SLEEP)
        else $error("left sleep with select high");
    a_result_held: assert property (state_q != ST_CONV |=> $stable(result_q))
        else $error("result changed outside conversion");
    a_sleep_wake: assert property (state_q == ST_SLEEP && !cs_hi |=> state_q == ST_OUT)
        else $error("select low did not wake");
    a_early_abort: assert property (state_q == ST_OUT && cs_hi && !seen_start_q
        && !start_sync_q[1] |=> state_q == ST_SLEEP)
        else $error("early release did not return to sleep");
    a_late_abort: assert property (state_q == ST_OUT && cs_hi && seen_start_q
        |=> state_q == ST_CONV ##1 busy_q)
        else $error("late release did not start conversion");
    a_word_done: assert property (state_q == ST_OUT && !cs_hi && done_sync_q[1]
        |=> state_q == ST_CONV)
        else $error("full word did not start conversion");
    a_conv_length: assert property ($rose(busy_q) |-> busy_q [*8])
        else $error("conversion shorter than expected");
    a_status_oe: assert property (cs_hi |=> !oe_q)
        else $error("output driven with select high");
    a_addr_apply: assert property (start_q |-> chan_addr == $past(link_addr_q))
        else $error("address not applied at conversion start");
    a_cal_slot: assert property ($rose(start_q) |-> cal_q)
        else $error("no calibration at conversion start");
    c_full_read: cover property (state_q == ST_OUT && done_sync_q[1] ##1 state_q == ST_CONV);
    c_late_abort: cover property (state_q == ST_OUT && cs_hi && seen_start_q);
    c_peek_sleep: cover property (state_q == ST_OUT ##1 state_q == ST_SLEEP);
    c_int_clock: cover property (sck_en_q && mode_q);
endmodule : acss_sequencer

// >>> acss_host_model.sv
// Host serial master model for the converter link
`timescale 1ns/1ps

module acss_host_model (
    // System clock
    input wire logic sys_clk,
    // Link pins
    input wire logic sck_wire,
    input wire logic serial_out_line,
    input wire logic serial_out_oe,
    output logic cs_n,
    output logic host_sck,
    output logic host_sck_oe,
    output logic serial_in_line,
    // Captured word
    output logic [31:0] rx_word,
    output logic rx_valid
);
    // ========================================================================
    // Idle levels
    // ========================================================================
    initial begin
        cs_n = 1'b1;
        host_sck = 1'b0;
        host_sck_oe = 1'b1;
        serial_in_line = 1'b1;
        rx_word = 32'h0;
        rx_valid = 1'b0;
    end

    // ========================================================================
    // One frame of n rising edges; n of 0 gives up before the first edge
    // ========================================================================
    task automatic frame(input logic [7:0] cmd, input int n, input logic im);
        logic [31:0] w;
        w = 32'h0;
        host_sck_oe <= ~im;  // Released line floats high: internal clock
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b0;
        serial_in_line <= cmd[7];  // Only legal control codes are sent
        if (!im) begin
            // Clocking before the done status would be lost
            wait (serial_out_oe === 1'b1 && serial_out_line === 1'b0);
            repeat (6) @(posedge sys_clk);
        end
        for (int k = 0; k < n; k++) begin
            if (!im) #40 host_sck <= 1'b1;
            @(posedge sck_wire);
            w[31-k] = serial_out_line;
            if (!im) #40 host_sck <= 1'b0;
            if (k < n - 1) begin
                @(negedge sck_wire);
                serial_in_line <= (k < 7) ? cmd[6-k] : ~serial_in_line;
            end
        end
        #40;
        @(posedge sys_clk);
        cs_n <= 1'b1;
        rx_word <= w;
        rx_valid <= (n > 0);
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : frame
endmodule : acss_host_model

// >>> acss_sequencer_bench.sv
// Self-checking bench of the converter cycle sequencer
`timescale 1ns/1ps

module acss_sequencer_bench import acss_pkg::*; ();
    // ========================================================================
    // Signals
    // ========================================================================
    logic sys_clk, rst_n, supply_low, conv_over, conv_under;
    logic [23:0] conv_data;
    // Design outputs
    logic sck_o, sck_oe, serial_out_line, serial_out_oe, conv_start, cal_phase, sck_int_mode;
    logic [4:0] chan_addr;
    // Host side
    logic cs_n, host_sck, host_sck_oe, serial_in_line, rx_valid;
    logic [31:0] rx_word;
    wire logic sck_wire;
    // Scoreboard
    logic [31:0] exp_q[$];
    logic [31:0] cur_exp;  // Word the stored result should read as
    logic [7:0] cmds[3] = '{8'h9f, 8'h1f, 8'hb5};
    logic [4:0] addrs[3] = '{5'h03, 5'h03, 5'h15};
    int n_mismatch = 0;
    int checks_done = 0;
    int n_conv = 0;
    int n_cal = 0;   // Cycles seen with the calibration slot high
    int base;
    int cal_base;

    // Shared clock line: device, else host, else the weak pull-up
    assign sck_wire = sck_oe ? sck_o : (host_sck_oe ? host_sck : 1'b1);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Short power-on count keeps the run brief
    acss_sequencer #(.POR_CYCLES(16), .CONV_CYCLES(64), .CAL_CYCLES(8), .SCK_DIV(4))
    i_acss_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .supply_low(supply_low),
        .link_sck(sck_wire), .sck_lvl(sck_wire), .sck_o(sck_o), .sck_oe(sck_oe),
        .cs_n(cs_n), .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
        .serial_out_oe(serial_out_oe), .conv_data(conv_data), .conv_over(conv_over),
        .conv_under(conv_under), .conv_start(conv_start), .cal_phase(cal_phase),
        .chan_addr(chan_addr), .sck_int_mode(sck_int_mode));

    acss_host_model i_acss_host_model (.sys_clk(sys_clk), .sck_wire(sck_wire),
        .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe), .cs_n(cs_n),
        .host_sck(host_sck), .host_sck_oe(host_sck_oe), .serial_in_line(serial_in_line),
        .rx_word(rx_word), .rx_valid(rx_valid));

    // ========================================================================
    // Checking helpers
    // ========================================================================
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Word layout worked out independently of the design
    function automatic logic [31:0] word_of(logic [23:0] d, logic o, logic u);
        if (o) return CODE_OVER;
        if (u) return CODE_UNDER;
        return {2'h0, ~d[23], d, 5'h00};
    endfunction : word_of

    // Conversion starts and calibration cycles, counted per frame
    always @(posedge sys_clk) begin
        if (conv_start === 1'b1) n_conv <= n_conv + 1;
        if (cal_phase === 1'b1) n_cal <= n_cal + 1;
    end

    // Each captured word is matched against the oldest note
    always @(posedge rx_valid) begin
        if (exp_q.size() == 0) check("word queue", 32'h1, 32'h0);
        else check("serial word", rx_word, exp_q.pop_front());
    end

    // New core data goes in during sleep, so only the next conversion sees it
    task automatic run(input logic [7:0] cmd, input int n, input logic im,
                       input logic o, input logic u);
        logic [23:0] d;
        d = 24'($urandom);
        @(posedge sys_clk);
        conv_data <= d;
        conv_over <= o;
        conv_under <= u;
        base = n_conv;
        cal_base = n_cal;
        if (n > 0) exp_q.push_back(cur_exp & ~(32'hffffffff >> n));
        i_acss_host_model.frame(cmd, n, im);
        repeat (90) @(posedge sys_clk);
        check("conversions", 32'(n_conv - base), (n > 0) ? 32'h1 : 32'h0);
        check("calibration cycles", 32'(n_cal - cal_base), (n > 0) ? 32'h8 : 32'h0);
        if (n > 0) cur_exp = word_of(d, o, u);
    endtask : run

    task automatic stop_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        rst_n = 1'b0;
        supply_low = 1'b0;
        conv_data = 24'h801234;
        conv_over = 1'b0;
        conv_under = 1'b0;
        void'($urandom(15));
        cur_exp = word_of(24'h801234, 1'b0, 1'b0);
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (120) @(posedge sys_clk);
        check("power-up address", 32'(chan_addr), 32'h0);
        check("output released", 32'(serial_out_oe), 32'h0);
        run(8'ha3, 0, 1'b0, 1'b0, 1'b0);
        run(8'ha3, 32, 1'b0, 1'b0, 1'b0);
        check("address load", 32'(chan_addr), 32'h3);
        for (int i = 0; i < 3; i++) begin
            // Each legal control code, frame cut after the command
            run(cmds[i], 8, 1'b0, 1'b0, 1'b0);
            check("address update", 32'(chan_addr), 32'(addrs[i]));
        end
        run(8'h80, 32, 1'b0, 1'b1, 1'b0);
        run(8'h80, 32, 1'b0, 1'b0, 1'b1);
        run(8'h80, 32, 1'b1, 1'b0, 1'b0);
        check("clock mode", 32'(sck_int_mode), 32'h1);
        run(8'h00, 32, 1'b0, 1'b0, 1'b0);
        check("clock mode", 32'(sck_int_mode), 32'h0);
        repeat (4) run({3'h4, 5'($urandom)}, 1 + int'($urandom_range(31)), 1'b0, 1'b0, 1'b0);
        // Supply dip in mid-run restarts from a clean power-on
        @(posedge sys_clk);
        supply_low <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check("held in reset", 32'(conv_start), 32'h1);
        supply_low <= 1'b0;
        repeat (120) @(posedge sys_clk);
        check("address cleared", 32'(chan_addr), 32'h0);
        cur_exp = word_of(conv_data, conv_over, conv_under);
        run(8'h80, 32, 1'b0, 1'b0, 1'b0);
        check("words left", 32'(exp_q.size()), 32'h0);
        stop_test();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #2000000;
        n_mismatch++;
        stop_test();
    end
endmodule : acss_sequencer_bench
